// ---- shared/spa_pkg.sv ----
// constants, types and decode helpers for the sequencing pin alternate-function block
package spa_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SPA_OFS_ALT_EN  = 8'h20;
  localparam logic [7:0] SPA_OFS_ALT_SEL = 8'h21;
  localparam logic [7:0] SPA_OFS_DRV_HI  = 8'h22;
  localparam logic [7:0] SPA_OFS_DRV_LO  = 8'h23;
  localparam logic [7:0] SPA_OFS_OSC     = 8'h24;
  localparam logic [7:0] SPA_OFS_GPO     = 8'h25;
  localparam logic [7:0] SPA_OFS_DEB     = 8'h26;
  localparam logic [7:0] SPA_OFS_LP      = 8'h27;

  // ----------------------------------------------------------------
  // implemented-bit masks, reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] SPA_MASK_ALT_EN  = 8'h0F;
  localparam logic [7:0] SPA_MASK_ALT_SEL = 8'h0E;
  localparam logic [7:0] SPA_MASK_DRV_HI  = 8'h0F;
  localparam logic [7:0] SPA_MASK_DRV_LO  = 8'hFF;
  localparam logic [7:0] SPA_MASK_OSC     = 8'hD0;
  localparam logic [7:0] SPA_MASK_GPO     = 8'hFF;
  localparam logic [7:0] SPA_MASK_DEB     = 8'hFE;
  localparam logic [7:0] SPA_MASK_LP      = 8'hFF;
  localparam logic [7:0] SPA_REG_RESET    = 8'h00;

  localparam int SPA_OSC_LOAD_BIT  = 7;
  localparam int SPA_OSC_XTAL_BIT  = 6;
  localparam int SPA_OSC_CLKPP_BIT = 4;
  localparam int SPA_DEB_TIME_LSB  = 4;
  localparam int SPA_DEB_EN_LSB    = 1;
  localparam int SPA_PIN12         = 3;
  localparam int SPA_PIN11         = 2;
  localparam int SPA_PIN10         = 1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         SPA_CLK_PERIOD_NS = 20;
  localparam int         SPA_MS_NS         = 1000000;
  localparam int         SPA_MS_CYCLES     = SPA_MS_NS / SPA_CLK_PERIOD_NS;
  localparam logic [6:0] SPA_DEB_STEP_MS   = 7'h05;
  localparam logic [6:0] SPA_LP_STEP_MS    = 7'h64;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } spa_wr_t;

  typedef enum logic [0:0] {
    SPA_RELEASED = 1'b0,
    SPA_PRESSED  = 1'b1
  } spa_press_t;

  // implemented bits of each register; unmapped addresses give zero
  function automatic logic [7:0] spa_reg_mask(input logic [7:0] addr);
    case (addr)
      SPA_OFS_ALT_EN:  spa_reg_mask = SPA_MASK_ALT_EN;
      SPA_OFS_ALT_SEL: spa_reg_mask = SPA_MASK_ALT_SEL;
      SPA_OFS_DRV_HI:  spa_reg_mask = SPA_MASK_DRV_HI;
      SPA_OFS_DRV_LO:  spa_reg_mask = SPA_MASK_DRV_LO;
      SPA_OFS_OSC:     spa_reg_mask = SPA_MASK_OSC;
      SPA_OFS_GPO:     spa_reg_mask = SPA_MASK_GPO;
      SPA_OFS_DEB:     spa_reg_mask = SPA_MASK_DEB;
      SPA_OFS_LP:      spa_reg_mask = SPA_MASK_LP;
      default:         spa_reg_mask = 8'h00;
    endcase
  endfunction

  // registers frozen once the non-volatile load has finished
  function automatic logic spa_is_cfg(input logic [7:0] addr);
    spa_is_cfg = (addr >= SPA_OFS_ALT_EN) && (addr <= SPA_OFS_OSC);
  endfunction

endpackage

// ---- hw/spa_debounce.sv ----
// debounce filter for one active-low alternate-function input
`timescale 1ns/10ps
module spa_debounce (
  input  wire logic       clk_i,     // system clock
  input  wire logic       arst_n_i,  // async reset, active low
  input  wire logic       tick_ms_i, // one-cycle pulse each millisecond
  input  wire logic       enable_i,  // filter on
  input  wire logic [6:0] limit_i,   // stable time in milliseconds
  input  wire logic       raw_i,     // raw pin level
  output logic            filt_o     // filtered level
);
  logic [6:0] stable_ms;

  // ----------------------------------------------------------------
  // filter
  // ----------------------------------------------------------------
  // idle level is high so a released button never looks pressed after reset
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      filt_o    <= 1'b1;
      stable_ms <= 7'h00;
    end
    else if (!enable_i || raw_i == filt_o)
    begin
      filt_o    <= raw_i;
      stable_ms <= 7'h00;
    end
    else if (tick_ms_i)
    begin
      // partial first millisecond is accepted: jitter below one tick
      if (stable_ms + 7'h01 >= limit_i)
      begin
        filt_o    <= raw_i;
        stable_ms <= 7'h00;
      end
      else
        stable_ms <= stable_ms + 7'h01;
    end
  end

endmodule // spa_debounce

// ---- hw/spa_pin_alt.sv ----
// sequencing pin alternate-function configuration, gating and button timing
//
// Behaviour
// - alt enable bits 3..0 map pins 12..9
// - alt enable ignored while sequencing fields nonzero
// - pin 12 select: output or power button
// - pin 11 select: output or reset input
// - pin 10 select: output or emergency powerdown
// - pin 9 select bit reads zero always
// - config registers frozen after non-volatile load
// - upper driver bits pick push-pull pins 12..9
// - lower driver bits pick push-pull pins 8..1
// - oscillator bit 7 selects crystal load
// - oscillator bit 6 enables crystal driver
// - oscillator bit 4 sets clock output push-pull
// - output bits 3..0 drive pins when unsequenced
// - output bits 7..4 drive outputs 4..1
// - output, debounce, threshold writable unless protected
// - debounce time is five ms per step
// - per-pin debounce enables for pins 12..10
// - long press threshold in 100 ms steps
`timescale 1ns/10ps
module spa_pin_alt #(
  parameter int MS_CYCLES = spa_pkg::SPA_MS_CYCLES      // clocks per millisecond
) (
  input  wire logic             CLK_SYS_I,         // 50 MHz system clock
  input  wire logic             ARST_N_I,          // async reset, active low
  input  wire spa_pkg::spa_wr_t REG_WR_I,          // software register write
  input  wire logic [7:0]       REG_RD_ADDR_I,     // software read address
  input  wire spa_pkg::spa_wr_t NVM_WR_I,          // non-volatile load write
  input  wire logic             NVM_DONE_I,        // load finished, level
  input  wire logic             CTL_PROTECT_I,     // control group protected
  input  wire logic [3:0]       SEQ_LOCK_I,        // pins 12..9 have sequencing slots
  input  wire logic [7:0]       PWR_EN_I,          // power enables, output bit order
  input  wire logic [7:0]       SLP_EN_I,          // sleep enables, output bit order
  input  wire logic [2:0]       PIN_RAW_N_I,       // raw levels of pins 12..10
  output logic [7:0]            REG_RDATA_O,       // read data, one cycle after address
  output logic [3:0]            ALT_ACTIVE_O,      // pins 12..9 in alternate role
  output logic                  PWR_BTN_MODE_O,    // pin 12 is power button input
  output logic                  EXT_RST_MODE_O,    // pin 11 is reset input
  output logic                  EMER_PD_MODE_O,    // pin 10 is emergency input
  output logic [7:0]            GPO_LEVEL_O,       // general output levels
  output logic [7:0]            GPO_ACTIVE_O,      // general output bit applies
  output logic [11:0]           PIN_PUSH_PULL_O,   // pins 12..1, 1 = push-pull
  output logic                  CRYSTAL_LOAD_O,    // 1 = internal load caps
  output logic                  CRYSTAL_EN_O,      // crystal driver on
  output logic                  CLKOUT_PP_O,       // slow clock output push-pull
  output logic                  POWER_BUTTON_N_O,  // filtered power button
  output logic                  EXT_RESET_N_O,     // filtered reset input
  output logic                  EMER_PD_N_O,       // filtered emergency input
  output logic                  SHORT_PRESS_O,     // one-cycle short press pulse
  output logic                  LONG_PRESS_O       // one-cycle long press pulse
);
  import spa_pkg::*;

  logic [7:0]  alt_enable, alt_select, drv_upper, drv_lower;
  logic [7:0]  osc_cfg, gpo_levels, deb_cfg, lp_thresh;
  logic        wr_go;
  logic [7:0]  wr_addr, wr_data;
  logic [15:0] ms_cnt;
  logic        tick_ms;
  logic [6:0]  deb_limit;
  logic [2:0]  pin_in_n;
  logic        btn_filt, btn_filt_d;
  spa_press_t  press_state, next_press_state;
  logic [6:0]  press_ms;
  logic [8:0]  press_units;
  logic [3:0]  alt_eff;

  // ----------------------------------------------------------------
  // write source selection
  // ----------------------------------------------------------------
  // until it finishes, a loader write takes priority over any register write; a software write in the
  // same cycle is dropped rather than queued, which keeps the load exact
  always_comb
  begin
    wr_go   = 1'b0;
    wr_addr = NVM_WR_I.addr;
    wr_data = NVM_WR_I.data;
    if (NVM_WR_I.wr && !NVM_DONE_I)
      wr_go = 1'b1;
    else if (REG_WR_I.wr)
    begin
      wr_addr = REG_WR_I.addr;
      wr_data = REG_WR_I.data;
      if (spa_is_cfg(REG_WR_I.addr))
        wr_go = !NVM_DONE_I;
      else
        wr_go = !CTL_PROTECT_I;
    end
  end

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      alt_enable <= SPA_REG_RESET;
      alt_select <= SPA_REG_RESET;
      drv_upper  <= SPA_REG_RESET;
      drv_lower  <= SPA_REG_RESET;
      osc_cfg    <= SPA_REG_RESET;
      gpo_levels <= SPA_REG_RESET;
      deb_cfg    <= SPA_REG_RESET;
      lp_thresh  <= SPA_REG_RESET;
    end
    else if (wr_go)
    begin
      // masking drops reserved bits and pins select bit 0 at zero
      case (wr_addr)
        SPA_OFS_ALT_EN:  alt_enable <= wr_data & spa_reg_mask(wr_addr);
        SPA_OFS_ALT_SEL: alt_select <= wr_data & spa_reg_mask(wr_addr);
        SPA_OFS_DRV_HI:  drv_upper  <= wr_data & spa_reg_mask(wr_addr);
        SPA_OFS_DRV_LO:  drv_lower  <= wr_data & spa_reg_mask(wr_addr);
        SPA_OFS_OSC:     osc_cfg    <= wr_data & spa_reg_mask(wr_addr);
        SPA_OFS_GPO:     gpo_levels <= wr_data & spa_reg_mask(wr_addr);
        SPA_OFS_DEB:     deb_cfg    <= wr_data & spa_reg_mask(wr_addr);
        SPA_OFS_LP:      lp_thresh  <= wr_data & spa_reg_mask(wr_addr);
        default:         ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      REG_RDATA_O <= 8'h00;
    else
      case (REG_RD_ADDR_I)
        SPA_OFS_ALT_EN:  REG_RDATA_O <= alt_enable;
        SPA_OFS_ALT_SEL: REG_RDATA_O <= alt_select;
        SPA_OFS_DRV_HI:  REG_RDATA_O <= drv_upper;
        SPA_OFS_DRV_LO:  REG_RDATA_O <= drv_lower;
        SPA_OFS_OSC:     REG_RDATA_O <= osc_cfg;
        SPA_OFS_GPO:     REG_RDATA_O <= gpo_levels;
        SPA_OFS_DEB:     REG_RDATA_O <= deb_cfg;
        SPA_OFS_LP:      REG_RDATA_O <= lp_thresh;
        default:         REG_RDATA_O <= 8'h00;
      endcase
  end

  // ----------------------------------------------------------------
  // pin role decode
  // ----------------------------------------------------------------
  // a stored enable stays readable but has no effect while sequencing owns the pin
  assign alt_eff = alt_enable[3:0] & ~SEQ_LOCK_I;

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ALT_ACTIVE_O    <= 4'h0;
      PWR_BTN_MODE_O  <= 1'b0;
      EXT_RST_MODE_O  <= 1'b0;
      EMER_PD_MODE_O  <= 1'b0;
      PIN_PUSH_PULL_O <= 12'h000;
      CRYSTAL_LOAD_O  <= 1'b0;
      CRYSTAL_EN_O    <= 1'b0;
      CLKOUT_PP_O     <= 1'b0;
    end
    else
    begin
      ALT_ACTIVE_O    <= alt_eff;
      PWR_BTN_MODE_O  <= alt_eff[SPA_PIN12] & alt_select[SPA_PIN12];
      EXT_RST_MODE_O  <= alt_eff[SPA_PIN11] & alt_select[SPA_PIN11];
      EMER_PD_MODE_O  <= alt_eff[SPA_PIN10] & alt_select[SPA_PIN10];
      PIN_PUSH_PULL_O <= {drv_upper[3:0], drv_lower};
      CRYSTAL_LOAD_O  <= osc_cfg[SPA_OSC_LOAD_BIT];
      CRYSTAL_EN_O    <= osc_cfg[SPA_OSC_XTAL_BIT];
      CLKOUT_PP_O     <= osc_cfg[SPA_OSC_CLKPP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // general outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      GPO_LEVEL_O  <= 8'h00;
      GPO_ACTIVE_O <= 8'h00;
    end
    else
    begin
      GPO_LEVEL_O       <= gpo_levels;
      GPO_ACTIVE_O <= ~PWR_EN_I & ~SLP_EN_I;
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick and input filters
  // ----------------------------------------------------------------
  assign tick_ms = (ms_cnt == 16'(MS_CYCLES - 1));
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      ms_cnt <= 16'h0000;
    else if (tick_ms)
      ms_cnt <= 16'h0000;
    else
      ms_cnt <= ms_cnt + 16'h0001;
  end

  assign deb_limit = 7'(SPA_DEB_STEP_MS * ({3'b000, deb_cfg[7:4]} + 7'h01));
  // pins not in input role look released so no stray press is seen
  assign pin_in_n  = {PIN_RAW_N_I[2] | ~PWR_BTN_MODE_O,
                      PIN_RAW_N_I[1] | ~EXT_RST_MODE_O,
                      PIN_RAW_N_I[0] | ~EMER_PD_MODE_O};

  spa_debounce u_deb_btn (
    .clk_i (CLK_SYS_I), .arst_n_i (ARST_N_I), .tick_ms_i (tick_ms), .limit_i (deb_limit),
    .enable_i (deb_cfg[SPA_DEB_EN_LSB + 2]), .raw_i (pin_in_n[2]), .filt_o (btn_filt)
  );

  spa_debounce u_deb_rst (
    .clk_i (CLK_SYS_I), .arst_n_i (ARST_N_I), .tick_ms_i (tick_ms), .limit_i (deb_limit),
    .enable_i (deb_cfg[SPA_DEB_EN_LSB + 1]), .raw_i (pin_in_n[1]), .filt_o (EXT_RESET_N_O)
  );

  spa_debounce u_deb_empd (
    .clk_i (CLK_SYS_I), .arst_n_i (ARST_N_I), .tick_ms_i (tick_ms), .limit_i (deb_limit),
    .enable_i (deb_cfg[SPA_DEB_EN_LSB]), .raw_i (pin_in_n[0]), .filt_o (EMER_PD_N_O)
  );

  assign POWER_BUTTON_N_O = btn_filt;

  // ----------------------------------------------------------------
  // press classification
  // ----------------------------------------------------------------
  always_comb
  begin
    next_press_state = press_state;
    case (press_state)
      SPA_RELEASED: if (btn_filt_d && !btn_filt) next_press_state = SPA_PRESSED;
      SPA_PRESSED:  if (btn_filt) next_press_state = SPA_RELEASED;
      default:      next_press_state = SPA_RELEASED;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      press_state <= SPA_RELEASED;
      btn_filt_d  <= 1'b1;
    end
    else
    begin
      press_state <= next_press_state;
      btn_filt_d  <= btn_filt;
    end
  end

  // duration counted in 100 ms units, saturating well above the largest threshold
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      press_ms    <= 7'h00;
      press_units <= 9'h000;
    end
    else if (press_state == SPA_RELEASED)
    begin
      press_ms    <= 7'h00;
      press_units <= 9'h000;
    end
    else if (tick_ms)
    begin
      if (press_ms == SPA_LP_STEP_MS - 7'h01)
      begin
        press_ms <= 7'h00;
        if (press_units != 9'h1FF)
          press_units <= press_units + 9'h001;
      end
      else
        press_ms <= press_ms + 7'h01;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      SHORT_PRESS_O <= 1'b0;
      LONG_PRESS_O  <= 1'b0;
    end
    else
    begin
      SHORT_PRESS_O <= 1'b0;
      LONG_PRESS_O  <= 1'b0;
      if (press_state == SPA_PRESSED && btn_filt && PWR_BTN_MODE_O)
      begin
        if (press_units >= {1'b0, lp_thresh} + 9'h001)
          LONG_PRESS_O <= 1'b1;
        else
          SHORT_PRESS_O <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!ARST_N_I);

  a_alt_lock_gate: assert property (
    (ALT_ACTIVE_O & $past(SEQ_LOCK_I)) == 4'h0)
    else $error("alternate role active on a sequenced pin");

  a_select_bit_zero: assert property (
    !alt_select[0])
    else $error("pin 9 select bit not zero");

  a_cfg_write_frozen: assert property (
    NVM_DONE_I && REG_WR_I.wr && REG_WR_I.addr == SPA_OFS_ALT_EN
    |=> $stable(alt_enable))
    else $error("config register changed after load");

  a_protect_holds_gpo: assert property (
    CTL_PROTECT_I && (NVM_DONE_I || !NVM_WR_I.wr) && REG_WR_I.wr
    && REG_WR_I.addr == SPA_OFS_GPO |=> $stable(gpo_levels))
    else $error("output register written while protected");

  a_button_mode_role: assert property (
    PWR_BTN_MODE_O |-> ALT_ACTIVE_O[SPA_PIN12] && $past(alt_select[SPA_PIN12]))
    else $error("power button mode without enable and select");

  a_gpo_gate_pin9: assert property (
    $past(PWR_EN_I[0]) |-> !GPO_ACTIVE_O[0])
    else $error("general output applied while sequenced");

  a_osc_reserved_zero: assert property (
    REG_RD_ADDR_I == SPA_OFS_OSC |=> (REG_RDATA_O & ~SPA_MASK_OSC) == 8'h00)
    else $error("reserved oscillator bits read nonzero");

  a_raw_passthrough: assert property (
    !deb_cfg[SPA_DEB_EN_LSB + 2] ##1 !deb_cfg[SPA_DEB_EN_LSB + 2]
    |-> btn_filt == $past(pin_in_n[2]))
    else $error("unfiltered button input not passed through");

  a_long_press_len: assert property (
    LONG_PRESS_O |-> $past(press_units) > {1'b0, $past(lp_thresh)})
    else $error("long press reported below threshold");

  a_press_one_pulse: assert property (
    SHORT_PRESS_O |=> !SHORT_PRESS_O && !LONG_PRESS_O)
    else $error("press pulse longer than one cycle");

  c_long_press:  cover property (LONG_PRESS_O);
  c_short_press: cover property (SHORT_PRESS_O);
  c_load_done:   cover property ($rose(NVM_DONE_I));
  c_reset_input: cover property (EXT_RST_MODE_O && !EXT_RESET_N_O);

endmodule // spa_pin_alt

// ---- dv/spa_pin_model.sv ----
// far-side model: power button and reset sources on pins 12..10
`timescale 1ns/10ps
module spa_pin_model (
  input  wire logic        clk_i,   // system clock
  input  wire logic [15:0] hold_i,  // press length in cycles
  input  wire logic        go_i,    // start a press
  input  wire logic [1:0]  lvl_n_i, // reset and emergency levels
  output logic [2:0]       raw_n_o  // pins 12..10, active low
);
  logic [15:0] cnt = 16'h0000;
  // a released button idles high, so nothing is pressed between presses
  always @(posedge clk_i)
    cnt <= go_i ? hold_i : ((cnt != 16'h0000) ? cnt - 16'h0001 : cnt);
  assign raw_n_o = {cnt == 16'h0000, lvl_n_i};
endmodule // spa_pin_model

// ---- dv/spa_pin_alt_test.sv ----
// self-checking bench for the sequencing pin alternate-function block
`timescale 1ns/10ps
module spa_pin_alt_test;
  import spa_pkg::*;
  localparam logic [7:0] MSK [8] = '{8'h0F, 8'h0E, 8'h0F, 8'hFF, 8'hD0, 8'hFF, 8'hFE, 8'hFF};
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  spa_wr_t     wr = '0;
  spa_wr_t     nvm = '0;
  logic [7:0]  rd_addr = 8'h00;
  logic        done = 1'b0;
  logic        prot = 1'b0;
  logic [3:0]  lock = 4'h0;
  logic [7:0]  pwr = 8'h00;
  logic [7:0]  slp = 8'h00;
  logic [15:0] hold = 16'h0000;
  logic        go = 1'b0;
  logic [1:0]  lvl_n = 2'b11;
  logic [2:0]  raw_n;
  logic [7:0]  rdata, gpo, gact, v;
  logic [3:0]  alt;
  logic [11:0] pp;
  logic        btn_m, rst_m, emr_m, cl, ce, cpp, btn_n, rst_n, emr_n, sp, lp;
  logic [7:0]  mirror [8] = '{default: 8'h00};
  logic [7:0]  rd_q [$];
  logic [1:0]  pr_q [$];
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  spa_pin_alt #(.MS_CYCLES(10)) i_dut (
    .CLK_SYS_I(clk), .ARST_N_I(arst_n), .REG_WR_I(wr), .REG_RD_ADDR_I(rd_addr),
    .NVM_WR_I(nvm), .NVM_DONE_I(done), .CTL_PROTECT_I(prot), .SEQ_LOCK_I(lock),
    .PWR_EN_I(pwr), .SLP_EN_I(slp), .PIN_RAW_N_I(raw_n), .REG_RDATA_O(rdata),
    .ALT_ACTIVE_O(alt), .PWR_BTN_MODE_O(btn_m), .EXT_RST_MODE_O(rst_m),
    .EMER_PD_MODE_O(emr_m), .GPO_LEVEL_O(gpo), .GPO_ACTIVE_O(gact),
    .PIN_PUSH_PULL_O(pp), .CRYSTAL_LOAD_O(cl), .CRYSTAL_EN_O(ce), .CLKOUT_PP_O(cpp),
    .POWER_BUTTON_N_O(btn_n), .EXT_RESET_N_O(rst_n), .EMER_PD_N_O(emr_n),
    .SHORT_PRESS_O(sp), .LONG_PRESS_O(lp));
  spa_pin_model i_model (.clk_i(clk), .hold_i(hold), .go_i(go), .lvl_n_i(lvl_n),
    .raw_n_o(raw_n));

  always #10 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // n selects the loader port; ok says whether the write should land
  task automatic reg_wr(input logic n, input logic ok, input logic [7:0] a,
                        input logic [7:0] d);
    @(negedge clk);
    if (n)
      nvm = '{1'b1, a, d};
    else
      wr = '{1'b1, a, d};
    if (ok)
      mirror[a[2:0]] = d & MSK[a[2:0]];
    @(negedge clk);
    nvm.wr = 1'b0;
    wr.wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(negedge clk);
    rd_addr = a;
    rd_q.push_back((a[7:3] == 5'h04) ? mirror[a[2:0]] : 8'h00);
  endtask

  task automatic press(input int n, input logic [1:0] k);
    @(negedge clk);
    hold = n[15:0];
    go = 1'b1;
    pr_q.push_back(k);
    @(negedge clk);
    go = 1'b0;
    repeat (5) @(negedge clk);
    chk(btn_n, 1'b0);
    repeat (n + 5) @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // result watcher and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    #1;
    if (rd_q.size() > 0)
      chk(rdata, rd_q.pop_front());
    if (sp === 1'b1 || lp === 1'b1)
      chk({lp, sp}, pr_q.pop_front());
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  initial
  begin
    v = 8'($urandom(32'h5e9b));
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    for (int a = 8'h20; a <= 8'h28; a++)
      reg_rd(a[7:0]);
    for (int a = 0; a < 5; a++)
      reg_wr(1'b1, 1'b1, 8'h20 + a[7:0], (a == 3) ? v : 8'hFF);
    for (int a = 8'h20; a <= 8'h24; a++)
      reg_rd(a[7:0]);
    lock = 4'h2;
    pwr = 8'($urandom);
    slp = 8'($urandom);
    lvl_n = 2'b00;
    repeat (4) @(negedge clk);
    chk(alt, mirror[0][3:0] & ~lock);
    chk({btn_m, rst_m, emr_m}, 3'b110);
    chk({btn_n, rst_n, emr_n}, 3'b101);
    chk(pp, {mirror[2][3:0], mirror[3]});
    chk({cl, ce, cpp}, 3'b111);
    chk(gact, 8'(~(pwr | slp)));
    lock = 4'h0;
    repeat (3) @(negedge clk);
    chk({emr_m, emr_n}, 2'b10);
    lvl_n = 2'b11;
    done = 1'b1;
    reg_wr(1'b0, 1'b0, 8'h20, 8'h00);
    reg_wr(1'b1, 1'b0, 8'h24, 8'h00);
    reg_rd(8'h20);
    reg_rd(8'h24);
    for (int a = 5; a < 8; a++)
    begin
      v = 8'($urandom);
      reg_wr(1'b0, 1'b1, 8'h20 + a[7:0], v);
      reg_rd(8'h20 + a[7:0]);
    end
    chk(gpo, mirror[5]);
    prot = 1'b1;
    reg_wr(1'b0, 1'b0, 8'h25, ~mirror[5]);
    reg_rd(8'h25);
    prot = 1'b0;
    // pin 11 filtered at the shortest step: 50 clocks with 10 per ms
    reg_wr(1'b0, 1'b1, 8'h26, 8'h04);
    lvl_n = 2'b01;
    repeat (35) @(negedge clk);
    chk(rst_n, 1'b1);
    repeat (35) @(negedge clk);
    chk(rst_n, 1'b0);
    lvl_n = 2'b11;
    reg_wr(1'b0, 1'b1, 8'h27, 8'h00);
    press(300, 2'b01);
    press(1100, 2'b10);
    repeat (5) @(negedge clk);
    print_verdict();
  end
endmodule // spa_pin_alt_test
